// file: include/vector_map_pkg.sv
// vector_map_pkg: shared constants and types of the peripheral interrupt vector map.
// assumes: one 100 MHz clock, APB register access with 32-bit data.
package vector_map_pkg;

	// ----------------------------------------------------------------
	// vector table geometry
	// ----------------------------------------------------------------
	localparam int unsigned NUM_VEC    = 32;
	localparam int unsigned VEC_W      = 5;
	localparam int unsigned VADDR_W    = 8;
	localparam int unsigned VEC_STRIDE = 2;	// vector addresses two apart
	localparam int unsigned SRC_W_DEF  = 8;	// sources one peripheral may own

	// vector numbers of the fixed peripheral instances
	localparam logic [4:0] VEC_RESET          = 5'h00;
	localparam logic [4:0] VEC_CRC_NMI        = 5'h01;
	localparam logic [4:0] VEC_VOLTAGE_LEVEL  = 5'h02;
	localparam logic [4:0] VEC_PIN_PORT_FIRST = 5'h03;
	localparam logic [4:0] VEC_PIN_PORT_SECOND = 5'h04;
	localparam logic [4:0] VEC_PIN_PORT_THIRD = 5'h05;
	localparam logic [4:0] VEC_REAL_TIME      = 5'h06;
	localparam logic [4:0] VEC_PERIODIC_TICK  = 5'h07;
	localparam logic [4:0] VEC_TIMER_A        = 5'h08;
	localparam logic [4:0] VEC_TIMER_B_FIRST  = 5'h0D;
	localparam logic [4:0] VEC_TIMER_B_SECOND = 5'h0E;
	localparam logic [4:0] VEC_TIMER_D        = 5'h0F;
	localparam logic [4:0] VEC_COMPARATOR_0   = 5'h11;
	localparam logic [4:0] VEC_COMPARATOR_1   = 5'h12;
	localparam logic [4:0] VEC_COMPARATOR_2   = 5'h13;
	localparam logic [4:0] VEC_CONVERTER_FIRST = 5'h14;
	localparam logic [4:0] VEC_CONVERTER_SECOND = 5'h16;
	localparam logic [4:0] VEC_TWO_WIRE       = 5'h18;
	localparam logic [4:0] VEC_SERIAL_PERIPH  = 5'h1A;
	localparam logic [4:0] VEC_SERIAL_RXTX    = 5'h1B;
	localparam logic [4:0] VEC_NONVOLATILE    = 5'h1E;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned PADDR_W        = 12;
	localparam logic [11:0] REG_GLOBAL     = 12'h000;
	localparam logic [11:0] REG_STATUS     = 12'h004;
	localparam logic [11:0] REG_PENDING    = 12'h008;
	localparam logic [3:0]  BANK_PAGE      = 4'h1;	// 0x100..0x1FF, 8 bytes per vector
	localparam int unsigned BANK_VEC_LSB   = 3;
	localparam int unsigned BANK_SEL_BIT   = 2;	// 0 flag register, 1 control register
	localparam int unsigned GIE_BIT        = 0;
	localparam logic        GIE_RESET      = 1'b0;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PADDR_W-1:0] paddr;
		logic               psel;
		logic               penable;
		logic               pwrite;
		logic [31:0]        pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic               nmi;	// non-maskable request, vector 1
		logic               req;	// maskable request present
		logic [VEC_W-1:0]   vector;
		logic [VADDR_W-1:0] addr;
	} irq_out_t;

	typedef struct packed {
		logic [16:0]        rsvd;
		logic               nmi;
		logic               req;
		logic [VEC_W-1:0]   vector;
		logic [VADDR_W-1:0] addr;
	} status_t;

	// vector n sits at twice n
	function automatic logic [VADDR_W-1:0] vector_address(input logic [VEC_W-1:0] v);
		vector_address = VADDR_W'(v * VEC_STRIDE);
	endfunction

endpackage

// file: design/source_bank.sv
// source_bank: flag and enable bits of all sources owned by one peripheral vector.
// assumes: events are one-cycle or level pulses from logic on the same clock.
`timescale 1ns/1ps
module source_bank #(
	parameter int unsigned SRC_W    = 8,
	parameter bit          MASKABLE = 1'b1
) (
	input  wire logic             mclk_i,
	input  wire logic             srst_i,
	input  wire logic [SRC_W-1:0] event_i,
	input  wire logic             wr_flag_i,
	input  wire logic             wr_ctrl_i,
	input  wire logic [SRC_W-1:0] wdata_i,
	output logic      [SRC_W-1:0] flag_o,
	output logic      [SRC_W-1:0] enable_o,
	output logic                  req_o
);

	typedef struct packed {
		logic [SRC_W-1:0] flag;
		logic [SRC_W-1:0] enable;
	} bank_state_t;

	bank_state_t s_q;
	bank_state_t s_d;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// a write of one clears a flag; an event in the same cycle wins
	always_comb begin
		s_d = s_q;
		if (wr_flag_i) begin
			s_d.flag = s_q.flag & ~wdata_i;
		end
		s_d.flag = s_d.flag | event_i;
		if (wr_ctrl_i && MASKABLE) begin
			s_d.enable = wdata_i;
		end
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// all sources share the one vector; the request drops once every enabled flag is clear
	assign flag_o   = s_q.flag;
	assign enable_o = MASKABLE ? s_q.enable : '1;
	assign req_o    = |(s_q.flag & enable_o);

endmodule // source_bank

// file: design/vector_map.sv
// vector_map: interrupt request generation and fixed vector mapping of peripherals.
// assumes: peripheral events on the same clock, APB master on the same clock,
// and a processor core that reads the registered request, vector and address.
//
// Notes on behaviour
// - each vector belongs to at most one peripheral; vector n sits at address 2n.
// - reset is vector 0 at 0x00; scan NMI is vector 1 at 0x02.
// - voltage monitor vector 2; three pin ports vectors 3, 4, 5.
// - real-time counter vector 6; its periodic tick timer vector 7.
// - timer A 8, timer B pair 13 and 14, timer D 15.
// - comparators 17 to 19; first converter 20; second converter 22.
// - two-wire 24, serial peripheral port 26, receiver-transmitter 27.
// - nonvolatile controller at vector 30, address 0x3C.
// - several sources of one peripheral share its single vector.
// - a source event sets its flag bit in the flag register.
// - software writes enable bits in the interrupt control register.
// - request raised exactly when enable bit and flag bit are both set.
// - request stays active while the flag stays set.
// - maskable requests reach the core only with global enable set.
`timescale 1ns/1ps
module vector_map #(
	parameter int unsigned SRC_W = vector_map_pkg::SRC_W_DEF
) (
	input  wire logic                                            mclk_i,
	input  wire logic                                            srst_i,
	input  wire vector_map_pkg::apb_req_t                        apb_i,
	output vector_map_pkg::apb_rsp_t                             apb_o,
	input  wire logic [vector_map_pkg::NUM_VEC-1:0][SRC_W-1:0]   events_i,
	output vector_map_pkg::irq_out_t                             irq_o
);

	localparam int unsigned NV = vector_map_pkg::NUM_VEC;

	// ----------------------------------------------------------------
	// vector ownership map
	// ----------------------------------------------------------------
	// one bit per vector; a clear bit means no bank is built there
	localparam logic [NV-1:0] ASSIGNED =
		(32'h1 << vector_map_pkg::VEC_CRC_NMI)
		| (32'h1 << vector_map_pkg::VEC_VOLTAGE_LEVEL)
		| (32'h1 << vector_map_pkg::VEC_PIN_PORT_FIRST)
		| (32'h1 << vector_map_pkg::VEC_PIN_PORT_SECOND)
		| (32'h1 << vector_map_pkg::VEC_PIN_PORT_THIRD)
		| (32'h1 << vector_map_pkg::VEC_REAL_TIME)
		| (32'h1 << vector_map_pkg::VEC_PERIODIC_TICK)
		| (32'h1 << vector_map_pkg::VEC_TIMER_A)
		| (32'h1 << vector_map_pkg::VEC_TIMER_B_FIRST)
		| (32'h1 << vector_map_pkg::VEC_TIMER_B_SECOND)
		| (32'h1 << vector_map_pkg::VEC_TIMER_D)
		| (32'h1 << vector_map_pkg::VEC_COMPARATOR_0)
		| (32'h1 << vector_map_pkg::VEC_COMPARATOR_1)
		| (32'h1 << vector_map_pkg::VEC_COMPARATOR_2)
		| (32'h1 << vector_map_pkg::VEC_CONVERTER_FIRST)
		| (32'h1 << vector_map_pkg::VEC_CONVERTER_SECOND)
		| (32'h1 << vector_map_pkg::VEC_TWO_WIRE)
		| (32'h1 << vector_map_pkg::VEC_SERIAL_PERIPH)
		| (32'h1 << vector_map_pkg::VEC_SERIAL_RXTX)
		| (32'h1 << vector_map_pkg::VEC_NONVOLATILE);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                     gie;
		vector_map_pkg::apb_rsp_t apb;
		vector_map_pkg::irq_out_t irq;
	} map_state_t;

	map_state_t s_q;
	map_state_t s_d;

	// per-vector bank views
	logic [NV-1:0][SRC_W-1:0] bank_flag;
	logic [NV-1:0][SRC_W-1:0] bank_en;
	logic [NV-1:0]            bank_req;
	logic [NV-1:0]            wr_flag;
	logic [NV-1:0]            wr_ctrl;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// lowest numbered pending vector wins, as a fixed priority
	function automatic logic [vector_map_pkg::VEC_W-1:0] lowest_set(input logic [NV-1:0] m);
		lowest_set = '0;
		for (int i = NV - 1; i >= 0; i--) begin
			if (m[i]) begin
				lowest_set = vector_map_pkg::VEC_W'(i);
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic                              in_bank;
	logic [vector_map_pkg::VEC_W-1:0]  bank_vec;
	logic                              bank_ctrl_sel;
	logic                              wr_commit;

	assign in_bank = (apb_i.paddr[vector_map_pkg::PADDR_W-1:8] == vector_map_pkg::BANK_PAGE);
	assign bank_vec = apb_i.paddr[vector_map_pkg::BANK_VEC_LSB +: vector_map_pkg::VEC_W];
	assign bank_ctrl_sel = apb_i.paddr[vector_map_pkg::BANK_SEL_BIT];
	// a write lands only at the edge that closes the access phase
	assign wr_commit = apb_i.psel && apb_i.penable && apb_i.pwrite && s_q.apb.pready
		&& !s_q.apb.pslverr;

	// bank write strobes; unassigned vectors never see a strobe
	always_comb begin
		wr_flag = '0;
		wr_ctrl = '0;
		if (wr_commit && in_bank && ASSIGNED[bank_vec]) begin
			if (bank_ctrl_sel) begin
				wr_ctrl[bank_vec] = 1'b1;
			end else begin
				wr_flag[bank_vec] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// source banks
	// ----------------------------------------------------------------
	for (genvar v = 0; v < NV; v++) begin : g_vec
		if (ASSIGNED[v]) begin : g_bank
			// the scan NMI bank has no enable: it is not maskable
			source_bank #(
				.SRC_W    (SRC_W),
				.MASKABLE (v != int'(vector_map_pkg::VEC_CRC_NMI))
			) u_bank (
				.mclk_i    (mclk_i),
				.srst_i    (srst_i),
				.event_i   (events_i[v]),
				.wr_flag_i (wr_flag[v]),
				.wr_ctrl_i (wr_ctrl[v]),
				.wdata_i   (apb_i.pwdata[SRC_W-1:0]),
				.flag_o    (bank_flag[v]),
				.enable_o  (bank_en[v]),
				.req_o     (bank_req[v])
			);
		end else begin : g_none
			// no source here, so events on this slot are dropped
			assign bank_flag[v] = '0;
			assign bank_en[v]   = '0;
			assign bank_req[v]  = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [NV-1:0]                    maskable_req;
	logic [vector_map_pkg::VEC_W-1:0] win_vec;
	vector_map_pkg::status_t          status;

	// maskable requests: everything but the NMI; global enable gates them later, at irq.req
	assign maskable_req = bank_req & ~(32'h1 << vector_map_pkg::VEC_CRC_NMI);
	assign win_vec = lowest_set(maskable_req);

	always_comb begin
		status        = '0;
		status.nmi    = s_q.irq.nmi;
		status.req    = s_q.irq.req;
		status.vector = s_q.irq.vector;
		status.addr   = s_q.irq.addr;
	end

	always_comb begin
		s_d = s_q;

		// setup phase prepares the answer; access phase then completes at once
		s_d.apb.pready  = apb_i.psel && !apb_i.penable;
		s_d.apb.pslverr = 1'b0;
		s_d.apb.prdata  = '0;
		if (apb_i.psel && !apb_i.penable) begin
			if (apb_i.paddr == vector_map_pkg::REG_GLOBAL) begin
				s_d.apb.prdata[vector_map_pkg::GIE_BIT] = s_q.gie;
			end else if (apb_i.paddr == vector_map_pkg::REG_STATUS) begin
				s_d.apb.prdata  = status;
				s_d.apb.pslverr = apb_i.pwrite;	// read-only
			end else if (apb_i.paddr == vector_map_pkg::REG_PENDING) begin
				s_d.apb.prdata  = 32'(bank_req);
				s_d.apb.pslverr = apb_i.pwrite;	// read-only
			end else if (in_bank && ASSIGNED[bank_vec]
				&& apb_i.paddr[1:0] == 2'h0) begin
				s_d.apb.prdata = bank_ctrl_sel ? 32'(bank_en[bank_vec])
					: 32'(bank_flag[bank_vec]);
			end else begin
				s_d.apb.pslverr = 1'b1;	// unmapped or unassigned vector
			end
		end

		// global enable register
		if (wr_commit && apb_i.paddr == vector_map_pkg::REG_GLOBAL) begin
			s_d.gie = apb_i.pwdata[vector_map_pkg::GIE_BIT];
		end

		// request toward the core; follows the flags with one cycle of delay
		s_d.irq.nmi = bank_req[vector_map_pkg::VEC_CRC_NMI];
		s_d.irq.req = s_q.gie && (|maskable_req);
		if (s_d.irq.nmi) begin
			s_d.irq.vector = vector_map_pkg::VEC_CRC_NMI;
		end else if (s_d.irq.req) begin
			s_d.irq.vector = win_vec;
		end else begin
			s_d.irq.vector = vector_map_pkg::VEC_RESET;	// idle shows reset vector
		end
		s_d.irq.addr = vector_map_pkg::vector_address(s_d.irq.vector);
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q     <= '0;
			s_q.gie <= vector_map_pkg::GIE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign apb_o = s_q.apb;
	assign irq_o = s_q.irq;

endmodule // vector_map

// file: test/vector_map_props.sv
// vector_map_props: port checks of the vector map.
// assumes: bound to vector_map; one clock, synchronous reset.
`timescale 1ns/1ps
module vector_map_props #(
	parameter int unsigned SRC_W = 8
) (
	input wire logic                                          mclk_i,
	input wire logic                                          srst_i,
	input wire vector_map_pkg::apb_req_t                      apb_i,
	input wire vector_map_pkg::apb_rsp_t                      apb_o,
	input wire logic [vector_map_pkg::NUM_VEC-1:0][SRC_W-1:0] events_i,
	input wire vector_map_pkg::irq_out_t                      irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// one bit per vector that has a peripheral behind it
	localparam logic [31:0] OWNED = 32'h4D5EE1FE;
	logic wr;
	logic gie_q;
	// any write in its access cycle
	assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite;
	// shadow of the global enable; a refused write leaves it alone
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			gie_q <= 1'b0;
		else if (wr && apb_o.pready && !apb_o.pslverr && apb_i.paddr == 12'h000)
			gie_q <= apb_i.pwdata[0];
	end
	addr_twice_a: assert property (irq_o.addr == {2'h0, irq_o.vector, 1'h0})
		else $error("vector address is not twice the vector");
	nmi_vector_a: assert property (irq_o.nmi |-> irq_o.addr == 8'h02)
		else $error("nmi not presented at vector 1");
	nmi_event_a: assert property (|events_i[1] |-> ##2 irq_o.nmi)
		else $error("scan event did not raise nmi");
	mask_global_a: assert property (irq_o.req |-> $past(gie_q))
		else $error("request with global enable clear");
	req_holds_a: assert property (irq_o.req && !wr && !$past(wr) |=> irq_o.req)
		else $error("request dropped with no write");
	owned_vec_a: assert property (irq_o.req |-> OWNED[irq_o.vector])
		else $error("request on a vector with no source");
	ready_next_a: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
		else $error("no ready in the access cycle");
	ready_access_a: assert property (apb_o.pready |-> apb_i.psel && apb_i.penable)
		else $error("ready outside an access cycle");
endmodule // vector_map_props

bind vector_map vector_map_props #(.SRC_W(SRC_W)) props (.mclk_i(mclk_i), .srst_i(srst_i),
	.apb_i(apb_i), .apb_o(apb_o), .events_i(events_i), .irq_o(irq_o));

// file: test/core_model.sv
// core_model: processor core that takes the vector on offer.
// assumes: irq_i registered on mclk_i; LAT+1 cycles pass before a fetch.
`timescale 1ns/1ps
module core_model #(
	parameter int unsigned LAT = 2
) (
	input  wire logic                     mclk_i,
	input  wire logic                     srst_i,
	input  wire vector_map_pkg::irq_out_t irq_i,
	output logic [7:0]                    fetch_o
);
	int unsigned wait_q;
	// slow core: a request must stand LAT+1 cycles before it is taken
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fetch_o <= 8'h00;	// restart at the reset vector
			wait_q  <= 0;
		end else if (irq_i.req || irq_i.nmi) begin
			wait_q <= wait_q + 1;
			if (wait_q == LAT)
				fetch_o <= irq_i.addr;	// vector n read at 2n
		end else begin
			wait_q <= 0;
		end
	end
endmodule // core_model

// file: test/vector_map_tb_top.sv
// tb top: APB and event driver with self checks for vector_map.
// assumes: package, design, core model and checker compiled before.
`timescale 1ns/1ps
module peripheral_interrupt_vector_map_tb_top;
	logic                                    mclk_i;
	logic                                    srst_i;
	vector_map_pkg::apb_req_t                apb_i;
	vector_map_pkg::apb_rsp_t                apb_o;
	logic [vector_map_pkg::NUM_VEC-1:0][7:0] events_i;
	vector_map_pkg::irq_out_t                irq_o;
	logic [7:0]                              fetch;
	logic [31:0]                             rd;
	logic                                    er;
	int                                      fails;
	int                                      checks;
	// maskable vectors that own a peripheral, and vectors that own none
	logic [4:0] vecs [19] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0D,
		5'h0E, 5'h0F, 5'h11, 5'h12, 5'h13, 5'h14, 5'h16, 5'h18, 5'h1A, 5'h1B, 5'h1E};
	logic [4:0] idle [12] = '{5'h00, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h15, 5'h17,
		5'h19, 5'h1C, 5'h1D, 5'h1F};

	vector_map #(.SRC_W(8)) uut (.mclk_i(mclk_i), .srst_i(srst_i), .apb_i(apb_i),
		.apb_o(apb_o), .events_i(events_i), .irq_o(irq_o));
	core_model #(.LAT(2)) core (.mclk_i(mclk_i), .srst_i(srst_i), .irq_i(irq_o),
		.fetch_o(fetch));

	// 100 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one transfer; request held until the rising edge that samples pready high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		apb_i <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge mclk_i);
		apb_i.penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (apb_o.pready !== 1'b1 && n < 20);
		if (apb_o.pready !== 1'b1)
			fails++;
		rd = apb_o.prdata;
		er = apb_o.pslverr;
		apb_i.psel    <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask
	task automatic settle;
		@(posedge mclk_i);
		@(negedge mclk_i);
	endtask
	// one-cycle event, then wait until irq_o has followed
	task automatic pulse(input logic [4:0] v, input int s);
		@(posedge mclk_i);
		events_i[v][s] <= 1'b1;
		@(posedge mclk_i);
		events_i[v][s] <= 1'b0;
		settle;
	endtask
	// request word laid out like the status register
	function automatic logic [31:0] irqv();
		return 32'({irq_o.nmi, irq_o.req, irq_o.vector, irq_o.addr});
	endfunction
	task automatic finish_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog: the tests need under 2000 cycles
	initial begin
		repeat (5000) @(posedge mclk_i);
		fails++;
		finish_test;
	end

	initial begin
		srst_i   = 1'b1;
		apb_i    = '0;
		events_i = '0;
		fails    = 0;
		checks   = 0;
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		settle;
		check(irqv(), 32'h0);
		check(32'(fetch), 32'h0);
		apb(12'h000, 1'b0, 32'h0);
		check(rd, 32'h0);
		$display("test reset done");
		// each owned vector but the NMI: enable, event, present, fetch, clear
		apb(12'h000, 1'b1, 32'h1);
		foreach (vecs[i]) begin
			apb({4'h1, vecs[i], 3'h4}, 1'b1, 32'h1);
			pulse(vecs[i], 0);
			check(irqv(), 32'({2'h1, vecs[i], 2'h0, vecs[i], 1'h0}));
			repeat (4) settle;
			check(32'(fetch), 32'({vecs[i], 1'h0}));
			apb({4'h1, vecs[i], 3'h0}, 1'b0, 32'h0);
			check(rd, 32'h1);
			apb({4'h1, vecs[i], 3'h0}, 1'b1, 32'h1);
			settle;
			check(32'(irq_o.req), 32'h0);
		end
		$display("test vector map done");
		// events where no peripheral sits stay silent
		@(posedge mclk_i);
		foreach (idle[i])
			events_i[idle[i]] <= 8'hFF;
		@(posedge mclk_i);
		events_i <= '0;
		repeat (2) settle;
		check(irqv(), 32'h0);
		apb({4'h1, 5'h09, 3'h0}, 1'b0, 32'h0);
		check(32'(er), 32'h1);
		apb(12'h00C, 1'b0, 32'h0);
		check(32'(er), 32'h1);
		$display("test silent vectors done");
		// source 5 of timer A: flag alone raises nothing
		apb({4'h1, 5'h08, 3'h4}, 1'b1, 32'h0);
		pulse(5'h08, 5);
		check(irqv(), 32'h0);
		apb({4'h1, 5'h08, 3'h0}, 1'b0, 32'h0);
		check(rd, 32'h20);
		apb({4'h1, 5'h08, 3'h4}, 1'b1, 32'h21);
		settle;
		check(irqv(), 32'h2810);
		apb({4'h1, 5'h08, 3'h4}, 1'b0, 32'h0);
		check(rd, 32'h21);
		repeat (6) settle;
		check(irqv(), 32'h2810);
		$display("test shared vector done");
		// global enable masks the request, not the pending bit
		apb(12'h000, 1'b1, 32'h0);
		settle;
		check(32'(irq_o.req), 32'h0);
		apb(12'h008, 1'b0, 32'h0);
		check(rd, 32'h100);
		apb(12'h000, 1'b1, 32'h1);
		settle;
		check(32'(irq_o.req), 32'h1);
		$display("test global enable done");
		// scan nmi outranks the pending timer
		pulse(5'h01, 0);
		check(irqv(), 32'h6102);
		apb(12'h004, 1'b0, 32'h0);
		check(rd, 32'h6102);
		apb({4'h1, 5'h01, 3'h0}, 1'b1, 32'h1);
		settle;
		check(irqv(), 32'h2810);
		apb({4'h1, 5'h08, 3'h0}, 1'b1, 32'h20);
		settle;
		check(irqv(), 32'h0);
		$display("test nmi done");
		finish_test;
	end
endmodule // peripheral_interrupt_vector_map_tb_top
